// [core/spis_pkg.sv]
package spis_pkg;
    // Clock and filter sample timing.
    localparam int CLK_HZ        = 40_000_000;
    localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int TICK_US       = 25;
    localparam int TICK_CYC      = TICK_US * CYC_PER_US;
    localparam int GAIN_FRAC     = 20;
    localparam int GAIN_W        = 16;
    // Speed filter time constants per dial position.
    localparam int TAU_MS [16]   = '{0, 1, 2, 3, 5, 7, 10, 20, 30, 50, 70, 100, 120, 150, 170, 200};
    // Alarm indicator timing.
    localparam int BLINK_ON_MS   = 200;
    localparam int BLINK_GAP_MS  = 1200;
    localparam int BLINK_ON_CYC  = BLINK_ON_MS * (CLK_HZ / 1000);
    localparam int BLINK_GAP_CYC = BLINK_GAP_MS * (CLK_HZ / 1000);
    localparam logic [3:0] ALM_THERMAL_BLINKS = 4'h3;
    // Settle time before the switch capture.
    localparam logic [2:0] CFG_SETTLE = 3'h4;
    // Values shown before the switches are captured.
    localparam logic [3:0] SW_BANK_RST  = 4'h0;
    localparam logic [3:0] CUR_DIAL_RST = 4'hF;
    localparam logic [3:0] FIL_DIAL_RST = 4'h1;
    // Register byte offsets.
    localparam logic [7:0] REG_STATUS    = 8'h00;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h04;
    localparam logic [7:0] REG_IRQ_EN    = 8'h08;
    localparam logic [7:0] REG_CONFIG    = 8'h0C;
    localparam logic [7:0] REG_POSITION  = 8'h10;
    localparam logic [7:0] REG_CONTROL   = 8'h14;
    localparam logic [31:0] IRQ_EN_RST   = 32'h0000_0000;
    // Status bit positions.
    localparam int ST_THERMAL  = 0;
    localparam int ST_IGNORED  = 1;
    localparam int ST_CONFLICT = 2;
    localparam int ST_W        = 3;
    // Control bit positions.
    localparam int CT_ALARM_RESET = 0;
    localparam int CT_INHIBIT     = 1;
    // Blink sequencer states.
    typedef enum logic [3:0] {
        BLK_IDLE = 4'h1,
        BLK_ON   = 4'h2,
        BLK_OFF  = 4'h4,
        BLK_GAP  = 4'h8
    } spis_blink_type;

    // Filter gain per sample tick, scaled by two to the GAIN_FRAC.
    function automatic int spis_gain(input int tau_ms);
        if (tau_ms == 0) begin
            return 0;
        end
        return ((1 << GAIN_FRAC) * TICK_US) / (tau_ms * 1000);
    endfunction : spis_gain
endpackage : spis_pkg

// [core/spis_speed_filter.sv]
`timescale 1ns/100ps
`default_nettype none
module spis_speed_filter #(
    parameter int POS_W = 32
) (
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic                      ce_i,
    input  wire logic                      step_i,
    input  wire logic                      dir_i,
    input  wire logic                      tick_i,
    input  wire logic                      bypass_i,
    input  wire logic [spis_pkg::GAIN_W-1:0] gain_i,
    output logic                           step_o,
    output logic                           dir_o,
    output logic [POS_W-1:0]               pos_o
);
    import spis_pkg::*;

    localparam int FW = POS_W + GAIN_FRAC;

    logic signed [POS_W-1:0]    cmd_pos;
    logic signed [POS_W-1:0]    out_pos;
    logic signed [FW-1:0]       filt_pos;
    logic signed [FW-1:0]       diff;
    logic signed [FW+GAIN_W:0]  prod;
    logic signed [POS_W-1:0]    target;

    // Commanded position follows every accepted step.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmd_pos <= '0;
        end else if (ce_i && step_i) begin
            cmd_pos <= dir_i ? cmd_pos + 1'b1 : cmd_pos - 1'b1;
        end
    end

    // A first-order lag on position is the same lag on step rate.
    assign diff = {cmd_pos, {GAIN_FRAC{1'b0}}} - filt_pos;
    assign prod = diff * $signed({1'b0, gain_i});

    // Filtered position; zero constant tracks the command exactly.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            filt_pos <= '0;
        end else if (ce_i) begin
            if (bypass_i) begin
                filt_pos <= {cmd_pos, {GAIN_FRAC{1'b0}}};
            end else if (tick_i) begin
                filt_pos <= filt_pos + prod[FW+GAIN_FRAC-1:GAIN_FRAC];
            end
        end
    end

    // Rounded filtered position is the target for the step generator.
    assign target = filt_pos[FW-1:GAIN_FRAC] + {{(POS_W-1){1'b0}}, filt_pos[GAIN_FRAC-1]};

    // At most one output step per clock.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_pos <= '0;
            step_o  <= 1'b0;
            dir_o   <= 1'b1;
        end else if (ce_i) begin
            if (out_pos != target) begin
                step_o  <= 1'b1;
                dir_o   <= target > out_pos;
                out_pos <= (target > out_pos) ? out_pos + 1'b1 : out_pos - 1'b1;
            end else begin
                step_o <= 1'b0;
            end
        end
    end

    assign pos_o = out_pos;
endmodule : spis_speed_filter
`default_nettype wire

// [core/spis_top.sv]
`timescale 1ns/100ps
`default_nettype none
module spis_top #(
    parameter int RES_0         = 1000,
    parameter int RES_1         = 500,
    parameter int RES_2         = 10000,
    parameter int RES_3         = 5000,
    parameter int POS_W         = 32,
    parameter int BLINK_ON_CYC  = spis_pkg::BLINK_ON_CYC,
    parameter int BLINK_GAP_CYC = spis_pkg::BLINK_GAP_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        step_pulse_input_i,
    input  wire logic        direction_input_i,
    input  wire logic        forward_pulse_input_i,
    input  wire logic        reverse_pulse_input_i,
    input  wire logic        resolution_select_i,
    input  wire logic        excitation_on_i,
    input  wire logic        thermal_input_b_i,
    input  wire logic [3:0]  setting_switch_bank_i,
    input  wire logic [3:0]  current_dial_i,
    input  wire logic [3:0]  speed_filter_dial_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             thermal_input_a_o,
    output logic             motor_step_o,
    output logic             motor_dir_o,
    output logic             motor_enable_o,
    output logic [4:0]       current_rate_o,
    output logic [31:0]      resolution_o,
    output logic             alarm_led_o,
    output logic             irq_o
);
    import spis_pkg::*;

    localparam int NPIN = 19;
    localparam int P_STEP = 0;
    localparam int P_DIR  = 1;
    localparam int P_FWD  = 2;
    localparam int P_REV  = 3;
    localparam int P_THM  = 4;
    localparam int P_EXC  = 5;
    localparam int P_RSEL = 6;
    localparam int P_SW   = 7;
    localparam int P_CUR  = 11;
    localparam int P_FIL  = 15;
    localparam int BW     = $clog2(BLINK_GAP_CYC + 1);
    localparam int TW     = $clog2(TICK_CYC + 1);

    // Byte offset to word slot; 7 marks an unmapped address.
    function automatic logic [2:0] spis_word(input logic [7:0] addr);
        case (addr)
            REG_STATUS:    spis_word = 3'h0;
            REG_IRQ_CLEAR: spis_word = 3'h1;
            REG_IRQ_EN:    spis_word = 3'h2;
            REG_CONFIG:    spis_word = 3'h3;
            REG_POSITION:  spis_word = 3'h4;
            REG_CONTROL:   spis_word = 3'h5;
            default:       spis_word = 3'h7;
        endcase
    endfunction : spis_word

    logic [NPIN-1:0]  pin_raw;
    logic [NPIN-1:0]  sync1;
    logic [NPIN-1:0]  sync2;
    logic [NPIN-1:0]  sync3;
    logic [NPIN-1:0]  pin_q;
    logic [NPIN-1:0]  pin_d;
    logic [NPIN-1:0]  rise;
    logic [2:0]       settle;
    logic             cfg_done;
    logic [3:0]       sw_bank;
    logic [3:0]       cur_dial;
    logic [3:0]       fil_dial;
    logic [1:0]       res_idx;
    logic             alarm;
    logic             inhibit;
    logic             alarm_reset;
    logic             step_evt;
    logic             step_dir;
    logic             pulse_seen;
    logic             conflict;
    logic [ST_W-1:0]  events;
    logic [ST_W-1:0]  status;
    logic [31:0]      irq_en;
    logic [ST_W-1:0]  clr_bits;
    logic             ap_take;
    logic             wr_pend;
    logic [2:0]       wr_word;
    logic [TW-1:0]    tick_cnt;
    logic             tick;
    logic [GAIN_W-1:0] gain_tab [16];
    logic [POS_W-1:0] position;
    logic             filt_step;
    logic             filt_dir;
    spis_blink_type   blink_state;
    logic [BW-1:0]    blink_cnt;
    logic [3:0]       blinks_left;

    assign pin_raw = {speed_filter_dial_i, current_dial_i, setting_switch_bank_i,
                      resolution_select_i, excitation_on_i, thermal_input_b_i,
                      reverse_pulse_input_i, forward_pulse_input_i,
                      direction_input_i, step_pulse_input_i};

    // Every pin passes three flops; a level counts once the last two agree.
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
                sync3[i] <= 1'b0;
                pin_q[i] <= 1'b0;
                pin_d[i] <= 1'b0;
            end else if (ce_i) begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                pin_d[i] <= pin_q[i];
                if (sync2[i] == sync3[i]) begin
                    pin_q[i] <= sync3[i];
                end
            end
        end
    end
    assign rise = pin_q & ~pin_d;

    // Switches are taken once after reset settles; later moves are ignored.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            settle   <= '0;
            cfg_done <= 1'b0;
            sw_bank  <= SW_BANK_RST;
            cur_dial <= CUR_DIAL_RST;
            fil_dial <= FIL_DIAL_RST;
        end else if (ce_i && !cfg_done) begin
            settle <= settle + 1'b1;
            if (settle == CFG_SETTLE) begin
                cfg_done <= 1'b1;
                sw_bank  <= pin_q[P_SW+:4];
                cur_dial <= pin_q[P_CUR+:4];
                fil_dial <= pin_q[P_FIL+:4];
            end
        end
    end

    // Select acts as switch 3 ON, so it is moot when 3 is ON.
    assign res_idx = {sw_bank[3], sw_bank[2] | pin_q[P_RSEL]};

    // Settings outputs.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            resolution_o   <= 32'h0000_0000;
            current_rate_o <= 5'h00;
        end else if (ce_i) begin
            case (res_idx)
                2'h0:    resolution_o <= 32'(RES_0);
                2'h1:    resolution_o <= 32'(RES_1);
                2'h2:    resolution_o <= 32'(RES_2);
                default: resolution_o <= 32'(RES_3);
            endcase
            current_rate_o <= {1'b0, cur_dial} + 5'h01;
        end
    end

    // Thermal loop is fed from one terminal and sensed on the other.
    assign thermal_input_a_o = 1'b1;

    // Alarm latches on an open loop and clears only by software once closed.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            alarm <= 1'b0;
        end else if (ce_i && cfg_done) begin
            if (!pin_q[P_THM]) begin
                alarm <= 1'b1;
            end else if (alarm_reset) begin
                alarm <= 1'b0;
            end
        end
    end

    // Drive is allowed only when configured, excited and free of alarms.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            motor_enable_o <= 1'b0;
        end else if (ce_i) begin
            motor_enable_o <= cfg_done & pin_q[P_EXC] & ~alarm & ~inhibit;
        end
    end

    // Pulse decode; coincident forward and reverse edges cancel out.
    always_comb begin
        conflict = 1'b0;
        if (sw_bank[0]) begin
            pulse_seen = rise[P_STEP];
            step_dir   = pin_q[P_DIR];
        end else begin
            pulse_seen = rise[P_FWD] | rise[P_REV];
            step_dir   = rise[P_FWD];
            conflict   = rise[P_FWD] & rise[P_REV];
        end
        step_evt = pulse_seen & ~conflict & motor_enable_o;
    end

    assign events[ST_THERMAL]  = cfg_done & ~pin_q[P_THM];
    assign events[ST_IGNORED]  = pulse_seen & ~motor_enable_o;
    assign events[ST_CONFLICT] = conflict;

    // Filter sample tick.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (ce_i) begin
            tick     <= tick_cnt == TW'(TICK_CYC - 1);
            tick_cnt <= (tick_cnt == TW'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
        end
    end

    // Gains follow the time constant table; position 0 yields the bypass.
    for (genvar g = 0; g < 16; g++) begin : g_gain
        assign gain_tab[g] = GAIN_W'(spis_gain(TAU_MS[g]));
    end

    spis_speed_filter #(
        .POS_W (POS_W)
    ) u_filter (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .step_i    (step_evt),
        .dir_i     (step_dir),
        .tick_i    (tick),
        .bypass_i  (fil_dial == 4'h0),
        .gain_i    (gain_tab[fil_dial]),
        .step_o    (filt_step),
        .dir_o     (filt_dir),
        .pos_o     (position)
    );

    // Filtered steps still stop at once when drive is withdrawn.
    assign motor_step_o = filt_step & motor_enable_o;
    assign motor_dir_o  = filt_dir;

    // Blink the cause count, then a long gap, for as long as the alarm stands.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            blink_state <= BLK_IDLE;
            blink_cnt   <= '0;
            blinks_left <= 4'h0;
            alarm_led_o <= 1'b0;
        end else if (ce_i) begin
            case (blink_state)
                BLK_IDLE: begin
                    alarm_led_o <= 1'b0;
                    if (alarm) begin
                        blink_state <= BLK_ON;
                        blink_cnt   <= BW'(BLINK_ON_CYC - 1);
                        blinks_left <= ALM_THERMAL_BLINKS;
                        alarm_led_o <= 1'b1;
                    end
                end
                BLK_ON: begin
                    if (blink_cnt != '0) begin
                        blink_cnt <= blink_cnt - 1'b1;
                    end else begin
                        alarm_led_o <= 1'b0;
                        blinks_left <= blinks_left - 1'b1;
                        blink_state <= (blinks_left == 4'h1) ? BLK_GAP : BLK_OFF;
                        blink_cnt   <= (blinks_left == 4'h1) ? BW'(BLINK_GAP_CYC - 1)
                                                             : BW'(BLINK_ON_CYC - 1);
                    end
                end
                BLK_OFF, BLK_GAP: begin
                    if (blink_cnt != '0) begin
                        blink_cnt <= blink_cnt - 1'b1;
                    end else if (!alarm) begin
                        blink_state <= BLK_IDLE;
                    end else begin
                        blink_state <= BLK_ON;
                        blink_cnt   <= BW'(BLINK_ON_CYC - 1);
                        alarm_led_o <= 1'b1;
                        if (blink_state == BLK_GAP) begin
                            blinks_left <= ALM_THERMAL_BLINKS;
                        end
                    end
                end
                default: begin
                    blink_state <= BLK_IDLE;
                    alarm_led_o <= 1'b0;
                end
            endcase
        end
    end

    // Bus address phase; only word-sized writes reach the registers, reads of any size are answered.
    assign ap_take     = hsel_i & htrans_i[1] & hready_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_pend  <= 1'b0;
            wr_word  <= 3'h7;
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wr_pend <= ap_take & hwrite_i & (hsize_i == 3'h2);
            wr_word <= spis_word(haddr_i[7:0]);
            if (ap_take && !hwrite_i) begin
                case (spis_word(haddr_i[7:0]))
                    3'h0:    hrdata_o <= 32'(status);
                    3'h2:    hrdata_o <= irq_en;
                    3'h3:    hrdata_o <= {8'h00, ALM_THERMAL_BLINKS, 1'b0, motor_enable_o,
                                          alarm, cfg_done, 2'h0, res_idx, fil_dial,
                                          cur_dial, sw_bank};
                    3'h4:    hrdata_o <= 32'(position);
                    3'h5:    hrdata_o <= {30'h0, inhibit, 1'b0};
                    default: hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Register writes land in the data phase.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_en      <= IRQ_EN_RST;
            inhibit     <= 1'b0;
            alarm_reset <= 1'b0;
        end else if (ce_i) begin
            alarm_reset <= wr_pend && wr_word == 3'h5 && hwdata_i[CT_ALARM_RESET];
            if (wr_pend && wr_word == 3'h2) begin
                irq_en <= hwdata_i;
            end
            if (wr_pend && wr_word == 3'h5) begin
                inhibit <= hwdata_i[CT_INHIBIT];
            end
        end
    end

    assign clr_bits = (wr_pend && wr_word == 3'h1) ? hwdata_i[ST_W-1:0] : '0;

    // Sticky status; a new event in the clearing cycle survives the clear.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            status <= '0;
            irq_o  <= 1'b0;
        end else if (ce_i) begin
            status <= (status & ~clr_bits) | events;
            irq_o  <= |(status & irq_en[ST_W-1:0]);
        end
    end
endmodule : spis_top
`default_nettype wire

// [testbench/spis_top_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module spis_top_monitor #(
    parameter int RES_0 = 1000,
    parameter int RES_1 = 500,
    parameter int RES_2 = 10000,
    parameter int RES_3 = 5000,
    parameter int BLINK_ON_CYC = 20
) (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        excitation_on_i,
    input wire logic        thermal_input_b_i,
    input wire logic [3:0]  setting_switch_bank_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        motor_step_o,
    input wire logic        motor_enable_o,
    input wire logic [4:0]  current_rate_o,
    input wire logic [31:0] resolution_o,
    input wire logic        alarm_led_o
);
    logic [3:0]  run_cnt;
    logic [31:0] led_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Saturating age since reset; latched checks wait for capture.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            run_cnt <= 4'h0;
        end else if (run_cnt != 4'hF) begin
            run_cnt <= run_cnt + 4'h1;
        end
    end
    // Length of the current flash.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !alarm_led_o) begin
            led_cnt <= 32'h0;
        end else begin
            led_cnt <= led_cnt + 32'h1;
        end
    end
    chk_step_needs_enable: assert property (motor_step_o |-> motor_enable_o)
        else $error("step while disabled");
    chk_excite_off_idle: assert property (!excitation_on_i [*8] |-> !motor_enable_o)
        else $error("enabled, excitation off");
    chk_thermal_blocks: assert property (!thermal_input_b_i [*8] |-> !motor_enable_o)
        else $error("enabled, loop open");
    chk_rate_in_range: assert property (run_cnt >= 4'h1 |-> current_rate_o inside {[5'h01:5'h10]})
        else $error("rate out of range");
    chk_res_legal: assert property (run_cnt >= 4'h1 |->
        resolution_o inside {RES_0, RES_1, RES_2, RES_3})
        else $error("resolution illegal");
    chk_dial_latched: assert property (run_cnt >= 4'hC |-> $stable(current_rate_o))
        else $error("rate changed");
    chk_sw3_select_ignored: assert property (run_cnt >= 4'hC && setting_switch_bank_i[2]
        |-> $stable(resolution_o))
        else $error("resolution moved, sw3 on");
    chk_alarm_starts: assert property (run_cnt >= 4'hC && $fell(thermal_input_b_i)
        |-> ##[1:30] alarm_led_o)
        else $error("no blink");
    chk_blink_width: assert property ($fell(alarm_led_o) |-> led_cnt == BLINK_ON_CYC)
        else $error("flash length");
    chk_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready/okay");
    cover property ($rose(motor_step_o));
    cover property ($fell(alarm_led_o));
    cover property (run_cnt >= 4'hC && resolution_o == RES_3);
endmodule : spis_top_monitor
bind spis_top spis_top_monitor #(.RES_0(RES_0), .RES_1(RES_1), .RES_2(RES_2), .RES_3(RES_3),
    .BLINK_ON_CYC(BLINK_ON_CYC)) mon (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .excitation_on_i(excitation_on_i),
    .thermal_input_b_i(thermal_input_b_i), .setting_switch_bank_i(setting_switch_bank_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .motor_step_o(motor_step_o),
    .motor_enable_o(motor_enable_o), .current_rate_o(current_rate_o),
    .resolution_o(resolution_o), .alarm_led_o(alarm_led_o));
`default_nettype wire

// [testbench/spis_pulse_src.sv]
`timescale 1ns/100ps
`default_nettype none
module spis_pulse_src (
    input  wire logic clk_i,
    output logic      step_o,
    output logic      dir_o,
    output logic      fwd_o,
    output logic      rev_o
);
    // Pins idle low, direction positive.
    initial begin
        step_o = 1'b0;
        dir_o = 1'b1;
        fwd_o = 1'b0;
        rev_o = 1'b0;
    end
    // Direction leads; each level holds four cycles for the pin filter.
    task automatic emit(input logic two, input logic pos);
        dir_o <= two ? ~dir_o : pos;
        repeat (4) @(posedge clk_i);
        step_o <= ~two;
        fwd_o <= two & pos;
        rev_o <= two & ~pos;
        repeat (4) @(posedge clk_i);
        step_o <= 1'b0;
        fwd_o <= 1'b0;
        rev_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : emit
endmodule : spis_pulse_src
`default_nettype wire

// [testbench/spis_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module spis_top_test;
    typedef struct packed {logic [3:0] bank; logic sel; logic pos; logic [1:0] ri, rt;}
        spis_row_type;
    localparam int RES [4] = '{1000, 500, 10000, 5000};
    localparam spis_row_type ROWS [4] = '{'{4'h1, 1'h0, 1'h1, 2'h0, 2'h1},
        '{4'h5, 1'h0, 1'h0, 2'h1, 2'h1}, '{4'h8, 1'h1, 1'h1, 2'h3, 2'h2},
        '{4'hC, 1'h0, 1'h0, 2'h3, 2'h3}};
    logic clk_i = 1'b0, sys_rst_i = 1'b1, exc = 1'b1, therm = 1'b1, sel = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [3:0] bank = 4'h1, cur = 4'h3, filt = 4'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, res, q;
    logic rdy, hresp, step_pin, dir_pin, fwd_pin, rev_pin, loop_a, mstep, mdir, men, led, irq;
    logic [4:0] rate;
    int err_count = 0, cmp_count = 0, step_cnt = 0, cyc = 0, s, n;
    spis_row_type r;
    spis_pulse_src pg (.clk_i(clk_i), .step_o(step_pin), .dir_o(dir_pin), .fwd_o(fwd_pin),
        .rev_o(rev_pin));
    spis_top #(.RES_0(RES[0]), .RES_1(RES[1]), .RES_2(RES[2]), .RES_3(RES[3]),
        .BLINK_ON_CYC(20), .BLINK_GAP_CYC(60)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ce_i(1'b1), .step_pulse_input_i(step_pin), .direction_input_i(dir_pin),
        .forward_pulse_input_i(fwd_pin), .reverse_pulse_input_i(rev_pin),
        .resolution_select_i(sel), .excitation_on_i(exc), .thermal_input_b_i(therm),
        .setting_switch_bank_i(bank), .current_dial_i(cur), .speed_filter_dial_i(filt),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy),
        .hresp_o(hresp), .thermal_input_a_o(loop_a), .motor_step_o(mstep), .motor_dir_o(mdir),
        .motor_enable_o(men), .current_rate_o(rate), .resolution_o(res),
        .alarm_led_o(led), .irq_o(irq));
    always #12.5 clk_i = ~clk_i;
    // Count steps; cut a hung run short.
    always @(posedge clk_i) begin
        step_cnt += (mstep === 1'b1);
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            conclude();
        end
    end
    // Report counts and verdict.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // Power cycle with the switches set before release.
    task automatic power_up(input logic [3:0] b, input logic [3:0] c, input logic [3:0] f);
        sys_rst_i <= 1'b1;
        bank <= b;
        cur <= c;
        filt <= f;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask : power_up
    // One word transfer; read data taken at the data-phase edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (rdy !== 1'b1);
        q = hrdata;
    endtask : bus
    // Count one group of flashes, up to a long rest.
    task automatic blinks(output int k);
        int low = 0;
        logic p = 1'b0;
        k = 0;
        while (low < 45) begin
            @(posedge clk_i);
            k += (led === 1'b1 && !p);
            p = led;
            low = p ? 0 : low + 1;
        end
    endtask : blinks
    initial begin
        repeat (3) @(posedge clk_i);
        `CHK({loop_a, men, led, irq, mstep, rate}, 10'h200)
        `CHK(rdy, 1'b1)
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(rate, 5'h10)
        $display("test reset done");
        // Excite before pulsing.
        exc <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            r = ROWS[i % 4];
            sel <= r.sel;
            power_up(r.bank, i[3:0], 4'h0);
            `CHK(rate, 5'(i + 1))
            `CHK(res, 32'(RES[r.ri]))
            s = step_cnt;
            pg.emit(~r.bank[0], r.pos);
            repeat (4) @(posedge clk_i);
            `CHK(step_cnt - s, 1)
            `CHK(mdir, r.pos)
            sel <= ~r.sel;
            repeat (8) @(posedge clk_i);
            `CHK(res, 32'(RES[r.rt]))
        end
        $display("test table done");
        power_up(4'h1, 4'h3, 4'h0);
        cur <= 4'h0;
        bank <= 4'h0;
        repeat (12) @(posedge clk_i);
        `CHK(rate, 5'h04)
        $display("test latch done");
        exc <= 1'b0;
        bus(1'b0, 8'h08, 32'h0);
        `CHK(q, 32'h0)
        s = step_cnt;
        pg.emit(1'b0, 1'b1);
        repeat (4) @(posedge clk_i);
        `CHK(step_cnt - s, 0)
        bus(1'b0, 8'h00, 32'h0);
        `CHK(q[1], 1'b1)
        bus(1'b1, 8'h08, 32'h2);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b1)
        bus(1'b1, 8'h04, 32'h2);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        bus(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
        $display("test excitation done");
        exc <= 1'b1;
        therm <= 1'b0;
        for (int j = 0; j < 2; j++) begin
            blinks(n);
            `CHK(n[3:0], spis_pkg::ALM_THERMAL_BLINKS)
        end
        `CHK(men, 1'b0)
        therm <= 1'b1;
        repeat (6) @(posedge clk_i);
        bus(1'b1, 8'h14, 32'h1);
        repeat (3) @(posedge clk_i);
        `CHK(men, 1'b1)
        $display("test alarm done");
        power_up(4'h1, 4'hF, 4'h1);
        s = step_cnt;
        pg.emit(1'b0, 1'b1);
        repeat (100) @(posedge clk_i);
        `CHK(step_cnt - s, 0)
        for (int k = 0; k < 45000 && step_cnt == s; k++) @(posedge clk_i);
        `CHK(step_cnt - s, 1)
        $display("test filter done");
        conclude();
    end
endmodule : spis_top_test
`default_nettype wire
